// ### shared/pnvm_params.svh
// Timing counts, command codes and reset values for the parallel programming port.
// Assumes a 20 MHz MCLK; included by the port design only, not by the package.
// Functional notes
// - Strobe action pair selects address, data, command, idle.
// - Ready line low while an operation runs.
// - Drive data bus only while output enable low.
// - Command and address persist across operations.
// - Address action with select-one high loads high byte.
// - Write strobe after flash loading programs page.
// - No-operation command ends programming, clears write state.
// - Write strobe, select-one low, programs EEPROM page.
// - Flash read gives low byte, select-one low.
// - Flash read with select-one high gives high byte.
// - EEPROM read outputs addressed byte.
// - Fuse write uses command, data byte, write strobe.
// - Fuse data zero programs bit, one erases it.
// - Select-one high, two low targets high fuse.
// - Select-one low, two high targets extended fuse.
// - Lock write uses command, zero bits program locks.
// - Lock mode three blocks boot lock programming.
// - Lock bits clear only through chip erase; RESETN also sets them all to one here.
// - Fuse read, selects low, gives low fuse byte.
// - Fuse read gives high and extended fuse bytes.
// - Fuse read, two low one high, gives locks.
// - Identification read outputs byte at address zero to two.
// - Identification read with select-one high gives calibration.
`ifndef PNVM_PARAMS_SVH
`define PNVM_PARAMS_SVH
`define PNVM_CMD_ERASE   8'h80
`define PNVM_CMD_WFUSE   8'h40
`define PNVM_CMD_WLOCK   8'h20
`define PNVM_CMD_WFLASH  8'h10
`define PNVM_CMD_WEE     8'h11
`define PNVM_CMD_RSIG    8'h08
`define PNVM_CMD_RFUSE   8'h04
`define PNVM_CMD_RFLASH  8'h02
`define PNVM_CMD_REE     8'h03
`define PNVM_CMD_NOP     8'h00
`define PNVM_FUSE_RESET  8'hFF
`define PNVM_LOCK_RESET  8'hFF
`define PNVM_BOOT_LOCKS  8'h3C
`define PNVM_PROG_US     2
`define PNVM_PROG_CYC    ((`PNVM_PROG_US * 20 + 0) > 0 ? `PNVM_PROG_US * 20 : 1)
`endif

// ### shared/pnvm_pkg.sv
// Types shared by the parallel programming port.
// Assumes the constants header sits beside it.
package pnvm_pkg;
    typedef enum logic [1:0] {
        PNVM_ACT_ADDR,
        PNVM_ACT_DATA,
        PNVM_ACT_CMD,
        PNVM_ACT_IDLE
    } pnvm_act_e;
    typedef enum logic [1:0] {
        PNVM_IDLE,
        PNVM_BUSY
    } pnvm_state_e;
endpackage : pnvm_pkg

// ### rtl/pnvm_fifo.sv
// Word FIFO standing between page-load capture and the page buffer.
// Assumes one clock and a synchronous active-low reset.
module pnvm_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0]    wr_q, wr_d, rd_q, rd_d;
    logic [AW:0]      cnt_q, cnt_d;
    logic             push, pop;

    // Pointer and count update; full and empty come straight from the count.
    always_comb begin
        in_ready  = (cnt_q != AW'(0) + (AW+1)'(DEPTH));
        out_valid = (cnt_q != '0);
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        wr_d      = push ? wr_q + 1'b1 : wr_q;
        rd_d      = pop ? rd_q + 1'b1 : rd_q;
        cnt_d     = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    // Registers.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
        end
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    assign out_data = mem_q[rd_q];
endmodule : pnvm_fifo

// ### rtl/pnvm_port.sv
// Parallel programming port: strobe decode, page buffers, memories, fuses and locks.
// Assumes all pins are asynchronous to MCLK and held stable around their strobes.
`include "pnvm_params.svh"
module pnvm_port import pnvm_pkg::*; #(
    parameter int  FLASH_WORDS = 1024,
    parameter int  EE_BYTES    = 256,
    parameter int  PAGE_WORDS  = 64,
    parameter int  PROG_CYC    = `PNVM_PROG_CYC,
    parameter logic [7:0] SIG0 = 8'h5A, // Arbitrary identity value.
    parameter logic [7:0] SIG1 = 8'hA5, // Arbitrary identity value.
    parameter logic [7:0] SIG2 = 8'h3C, // Arbitrary identity value.
    parameter logic [7:0] CAL  = 8'h80
) (
    // Clock and reset.
    input  wire logic       MCLK,
    input  wire logic       RESETN,
    // Programmer control pins.
    input  wire logic       ACTION_SELECT_HI,
    input  wire logic       ACTION_SELECT_LO,
    input  wire logic       BYTE_SELECT_ONE,
    input  wire logic       BYTE_SELECT_TWO,
    input  wire logic       CRYSTAL_INPUT_STROBE,
    input  wire logic       WRITE_N,
    input  wire logic       PAGE_LOAD_STROBE,
    input  wire logic       OUTPUT_ENABLE_N,
    // Data bus.
    input  wire logic [7:0] DATA_IN,
    output logic      [7:0] DATA_OUT,
    output logic            DATA_OE,
    // Status.
    output logic            READY_BUSY
);
    localparam int FAW = $clog2(FLASH_WORDS);
    localparam int EAW = $clog2(EE_BYTES);
    localparam int PAW = $clog2(PAGE_WORDS);

    ////////////////////////////////////////////////////////////////////////////
    // Three-stage synchronisers; edges are taken where stages two and three differ.
    logic [12:0] s1_q, s2_q, s3_q, pin;
    logic [7:0]  din;
    assign pin = {ACTION_SELECT_HI, ACTION_SELECT_LO, BYTE_SELECT_ONE, BYTE_SELECT_TWO,
                  CRYSTAL_INPUT_STROBE, WRITE_N, PAGE_LOAD_STROBE, OUTPUT_ENABLE_N,
                  4'h0, 1'b0};
    logic [7:0] d1_q, d2_q, d3_q;
    always_ff @(posedge MCLK) begin
        s1_q <= pin;
        s2_q <= s1_q;
        s3_q <= s2_q;
        d1_q <= DATA_IN;
        d2_q <= d1_q;
        d3_q <= d2_q;
    end
    logic xs_rise, wr_fall, pl_rise, bs1, bs2, oe_n;
    logic [1:0] act;
    assign din     = d3_q;
    assign act     = s3_q[12:11];
    assign bs1     = s3_q[10];
    assign bs2     = s3_q[9];
    assign xs_rise = s2_q[8] && !s3_q[8];
    assign wr_fall = !s2_q[7] && s3_q[7];
    assign pl_rise = s2_q[6] && !s3_q[6];
    assign oe_n    = s3_q[5];

    ////////////////////////////////////////////////////////////////////////////
    // Control state: command, address, data and nonvolatile contents.
    pnvm_state_e st_q, st_d;
    logic [7:0]  cmd_q, cmd_d, ahi_q, ahi_d, alo_q, alo_d, dlo_q, dlo_d, dhi_q, dhi_d;
    logic [7:0]  fl_q, fl_d, fh_q, fh_d, fx_q, fx_d, lk_q, lk_d;
    logic [$clog2(PROG_CYC+1)-1:0] tm_q, tm_d;
    logic        wen_q, wen_d;
    logic        pg_fl, pg_ee, erase_go;
    logic [15:0] addr;
    assign addr = {ahi_q, alo_q};

    // Decode of strobes into next values; programming runs only when idle.
    always_comb begin
        st_d  = st_q;
        cmd_d = cmd_q;
        ahi_d = ahi_q;
        alo_d = alo_q;
        dlo_d = dlo_q;
        dhi_d = dhi_q;
        fl_d  = fl_q;
        fh_d  = fh_q;
        fx_d  = fx_q;
        lk_d  = lk_q;
        tm_d  = tm_q;
        wen_d = wen_q;
        pg_fl = 1'b0;
        pg_ee = 1'b0;
        erase_go = 1'b0;
        if (st_q == PNVM_BUSY) begin
            tm_d = tm_q - 1'b1;
            if (tm_q == '0 + 1'b1) begin
                st_d = PNVM_IDLE;
            end
        end else if (xs_rise) begin
            case (pnvm_act_e'(act))
                PNVM_ACT_ADDR: begin
                    if (bs1) ahi_d = din;
                    else alo_d = din;
                end
                PNVM_ACT_DATA: begin
                    if (bs1) dhi_d = din;
                    else dlo_d = din;
                end
                PNVM_ACT_CMD: begin
                    cmd_d = din;
                    wen_d = (din != `PNVM_CMD_NOP);
                end
                default: ;
            endcase
        end else if (wr_fall && wen_q) begin
            st_d = PNVM_BUSY;
            tm_d = ($bits(tm_q))'(PROG_CYC);
            case (cmd_q)
                `PNVM_CMD_WFLASH: pg_fl = 1'b1;
                `PNVM_CMD_WEE:    pg_ee = !bs1;
                `PNVM_CMD_WFUSE: begin
                    // Zero programs, one erases: the byte is simply stored.
                    if (bs1 && !bs2) fh_d = dlo_q;
                    else if (!bs1 && bs2) fx_d = dlo_q;
                    else if (!bs1) fl_d = dlo_q;
                end
                `PNVM_CMD_WLOCK: begin
                    // Writes only program; bits never return to one here.
                    if (!lk_q[0] && !lk_q[1]) begin
                        lk_d = lk_q & (dlo_q | `PNVM_BOOT_LOCKS);
                    end else begin
                        lk_d = lk_q & dlo_q;
                    end
                end
                `PNVM_CMD_ERASE: begin
                    lk_d = `PNVM_LOCK_RESET;
                    erase_go = 1'b1;
                end
                default: ;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESETN) begin
            st_q  <= PNVM_IDLE;
            cmd_q <= `PNVM_CMD_NOP;
            ahi_q <= 8'h00;
            alo_q <= 8'h00;
            dlo_q <= 8'hFF;
            dhi_q <= 8'hFF;
            fl_q  <= `PNVM_FUSE_RESET;
            fh_q  <= `PNVM_FUSE_RESET;
            fx_q  <= `PNVM_FUSE_RESET;
            lk_q  <= `PNVM_LOCK_RESET;
            tm_q  <= '0;
            wen_q <= 1'b0;
        end else begin
            st_q  <= st_d;
            cmd_q <= cmd_d;
            ahi_q <= ahi_d;
            alo_q <= alo_d;
            dlo_q <= dlo_d;
            dhi_q <= dhi_d;
            fl_q  <= fl_d;
            fh_q  <= fh_d;
            fx_q  <= fx_d;
            lk_q  <= lk_d;
            tm_q  <= tm_d;
            wen_q <= wen_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Page loads pass through the FIFO; the drain stalls while a page programs,
    // so the FIFO really fills and a full FIFO drops further page loads.
    logic        f_rdy, f_val;
    logic [31:0] f_dat;
    logic [15:0] pbuf_q [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] pvld_q;
    logic        ld_ok;
    assign ld_ok = pl_rise && (cmd_q == `PNVM_CMD_WFLASH || cmd_q == `PNVM_CMD_WEE);
    pnvm_fifo #(.WIDTH(32), .DEPTH(32)) u_fifo (
        .clk       (MCLK),
        .rst_n     (RESETN),
        .in_valid  (ld_ok),
        .in_ready  (f_rdy),
        .in_data   ({addr, dhi_q, dlo_q}),
        .out_valid (f_val),
        .out_ready (st_q == PNVM_IDLE),
        .out_data  (f_dat)
    );

    // Memories and the page commit; a chip erase fills only the first PAGE_WORDS flash words with ones.
    logic [15:0] flash_q [FLASH_WORDS];
    logic [7:0]  ee_q [EE_BYTES];
    logic [PAW-1:0] pidx;
    assign pidx = f_dat[16 +: PAW];
    always_ff @(posedge MCLK) begin
        if (!RESETN || pg_fl || pg_ee) begin
            pvld_q <= '0;
        end else if (f_val && st_q == PNVM_IDLE) begin
            pvld_q[pidx] <= 1'b1;
        end
        if (f_val && st_q == PNVM_IDLE) begin
            pbuf_q[pidx] <= f_dat[15:0];
        end
    end
    // One process owns each memory array, so no entry is driven from two places.
    always_ff @(posedge MCLK) begin
        for (int i = 0; i < PAGE_WORDS; i++) begin
            if (erase_go) begin
                flash_q[FAW'(i)] <= 16'hFFFF;
            end else if (pg_fl && pvld_q[i]) begin
                flash_q[FAW'({addr[FAW-1:PAW], PAW'(i)})] <= pbuf_q[i];
            end
            if (pg_ee && pvld_q[i]) begin
                ee_q[EAW'({addr[EAW-1:PAW], PAW'(i)})] <= pbuf_q[i][7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux; the bus is driven only while output enable is low.
    logic [7:0] rd_d, rd_q;
    logic [15:0] fw;
    assign fw = flash_q[addr[FAW-1:0]];
    always_comb begin
        rd_d = 8'h00;
        case (cmd_q)
            `PNVM_CMD_RFLASH: rd_d = bs1 ? fw[15:8] : fw[7:0];
            `PNVM_CMD_REE:    rd_d = ee_q[addr[EAW-1:0]];
            `PNVM_CMD_RFUSE: begin
                case ({bs2, bs1})
                    2'b00:   rd_d = fl_q;
                    2'b11:   rd_d = fh_q;
                    2'b10:   rd_d = fx_q;
                    default: rd_d = lk_q;
                endcase
            end
            `PNVM_CMD_RSIG: begin
                if (bs1) rd_d = CAL;
                else if (alo_q == 8'h00) rd_d = SIG0;
                else if (alo_q == 8'h01) rd_d = SIG1;
                else if (alo_q == 8'h02) rd_d = SIG2;
            end
            default: ;
        endcase
    end
    always_ff @(posedge MCLK) begin
        if (!RESETN) rd_q <= 8'h00;
        else rd_q <= rd_d;
    end
    assign DATA_OUT   = rd_q;
    assign DATA_OE    = RESETN && !oe_n;
    assign READY_BUSY = (st_q == PNVM_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // Checks.
    a_busy_after_wr: assert property (@(posedge MCLK) disable iff (!RESETN)
        (wr_fall && wen_q && st_q == PNVM_IDLE) |=> !READY_BUSY) else $error("busy missing");
    a_oe_drive: assert property (@(posedge MCLK) disable iff (!RESETN)
        DATA_OE == !oe_n) else $error("bus drive wrong");
    a_cmd_hold: assert property (@(posedge MCLK) disable iff (!RESETN)
        !(xs_rise && act == 2'b10) |=> $stable(cmd_q)) else $error("command lost");
    a_ahi_load: assert property (@(posedge MCLK) disable iff (!RESETN)
        (xs_rise && act == 2'b00 && bs1 && st_q == PNVM_IDLE) |=> ahi_q == $past(din))
        else $error("high address");
    a_nop_clear: assert property (@(posedge MCLK) disable iff (!RESETN)
        (xs_rise && act == 2'b10 && din == 8'h00 && st_q == PNVM_IDLE) |=> !wen_q)
        else $error("nop kept write");
    a_lock_noclear: assert property (@(posedge MCLK) disable iff (!RESETN)
        (cmd_q != `PNVM_CMD_ERASE) |=> ((lk_q & ~$past(lk_q)) == 8'h00))
        else $error("lock cleared");
    a_boot_keep: assert property (@(posedge MCLK) disable iff (!RESETN)
        (lk_q[1:0] == 2'b00 && cmd_q == `PNVM_CMD_WLOCK) |=>
        ((lk_q & 8'h3C) == ($past(lk_q) & 8'h3C))) else $error("boot lock changed");
    a_ready_back: assert property (@(posedge MCLK) disable iff (!RESETN)
        $fell(READY_BUSY) |-> ##[1:1000] READY_BUSY) else $error("never ready");
    // A strobe that arrives while a page programs must not disturb the address.
    a_busy_ignore: assert property (@(posedge MCLK) disable iff (!RESETN)
        (st_q == PNVM_BUSY) |=> $stable(ahi_q)) else $error("strobe taken while busy");
endmodule : pnvm_port

// ### testbench/pnvm_prog_model.sv
// Behavioural programmer that drives the port's pins at the falling edge of the clock.
// Assumes the device's data bus answer and ready line are wired back to it.
module pnvm_prog_model import pnvm_pkg::*; (
    // Clock and device answers.
    input  wire logic       clk,
    input  wire logic [7:0] dev_data,
    input  wire logic       dev_oe,
    input  wire logic       dev_rdy,
    // Pins towards the device.
    output logic            act_hi,
    output logic            act_lo,
    output logic            bs_one,
    output logic            bs_two,
    output logic            xtal,
    output logic            wr_n,
    output logic            page_load_strobe,
    output logic            oe_n,
    output wire logic [7:0] data_in
);
    logic [7:0] drv_q;
    // Bus level: the device wins while it drives, else the programmer's byte.
    assign data_in = dev_oe ? dev_data : drv_q;
    initial begin
        {act_hi, act_lo, bs_one, bs_two} = 4'b1100;
        {xtal, wr_n, page_load_strobe, oe_n} = 4'b0101;
        drv_q = 8'h00;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge clk);
    endtask : idle
    // Levels settle five cycles around each strobe so the pin synchronisers see them.
    task automatic load(input pnvm_act_e act, input logic b1, input logic [7:0] d);
        @(negedge clk);
        {act_hi, act_lo} = act;
        bs_one = b1;
        drv_q = d;
        idle(5);
        xtal = 1'b1;
        idle(5);
        xtal = 1'b0;
        idle(5);
    endtask : load
    task automatic latch();
        bs_one = 1'b1;
        idle(5);
        page_load_strobe = 1'b1;
        idle(5);
        page_load_strobe = 1'b0;
        idle(5);
    endtask : latch
    // The ready level is sampled while the write strobe is still low.
    task automatic write_pulse(input logic b1, input logic b2, output logic rdy);
        bs_one = b1;
        bs_two = b2;
        idle(5);
        wr_n = 1'b0;
        idle(7);
        rdy = dev_rdy;
        wr_n = 1'b1;
        idle(1);
    endtask : write_pulse
    // The released bus shows the inverse of its last byte, so a stale value cannot pass.
    task automatic read(input logic b1, input logic b2, output logic [7:0] v);
        drv_q = ~drv_q;
        bs_one = b1;
        bs_two = b2;
        oe_n = 1'b0;
        idle(8);
        v = data_in;
        oe_n = 1'b1;
        idle(5);
    endtask : read
endmodule : pnvm_prog_model

// ### testbench/testbench.sv
// Self-checking bench for the parallel programming port, page FIFO included.
// Assumes the programmer model beside it and a 20 MHz clock.
module testbench;
    import pnvm_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PW = 8;
    localparam logic [7:0] SIG [3] = '{8'h21, 8'h43, 8'h65}; // Arbitrary identity values.
    localparam logic [7:0] CAL = 8'h9C;
    logic clk, rst_n, ah, al, b1, b2, xt, wrn, pl, oen, oe, rdy, busy;
    logic [7:0] din, dout, v, d8;
    logic [15:0] d16;
    int failures, n_checks, i;
    logic [15:0] flash_m [int];
    logic [7:0] ee_m [int];
    logic [7:0] fuse_m [3];
    logic [7:0] lock_m;
    const logic fb1 [3] = '{1'b0, 1'b1, 1'b0};
    const logic fb2 [3] = '{1'b0, 1'b0, 1'b1};
    ////////////////////////////////////////////////////////////////////////////////
    pnvm_port #(.PAGE_WORDS(PW), .PROG_CYC(10), .SIG0(SIG[0]), .SIG1(SIG[1]),
        .SIG2(SIG[2]), .CAL(CAL)) dut_u (.MCLK(clk), .RESETN(rst_n),
        .ACTION_SELECT_HI(ah), .ACTION_SELECT_LO(al), .BYTE_SELECT_ONE(b1),
        .BYTE_SELECT_TWO(b2), .CRYSTAL_INPUT_STROBE(xt), .WRITE_N(wrn),
        .PAGE_LOAD_STROBE(pl), .OUTPUT_ENABLE_N(oen), .DATA_IN(din),
        .DATA_OUT(dout), .DATA_OE(oe), .READY_BUSY(rdy));
    pnvm_prog_model prog_u (.clk(clk), .dev_data(dout), .dev_oe(oe), .dev_rdy(rdy),
        .act_hi(ah), .act_lo(al), .bs_one(b1), .bs_two(b2), .xtal(xt), .wr_n(wrn),
        .page_load_strobe(pl), .oe_n(oen), .data_in(din));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic report_and_stop();
        if (failures == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // A write must drop the ready line, then raise it again within a bounded wait.
    task automatic do_write(input logic s1, input logic s2);
        int k;
        prog_u.write_pulse(s1, s2, busy);
        check(busy, 0);
        for (k = 0; k < 100 && rdy !== 1'b1; k++) @(negedge clk);
        if (k == 100) begin
            failures++;
            report_and_stop();
        end
    endtask : do_write
    task automatic rd_chk(input logic s1, input logic s2, input logic [7:0] exp);
        prog_u.read(s1, s2, v);
        check(v, exp);
        check(oe, 0);
    endtask : rd_chk
    task automatic erase();
        prog_u.load(PNVM_ACT_CMD, 0, 8'h80);
        do_write(0, 0);
        lock_m = 8'hFF;
    endtask : erase
    ////////////////////////////////////////////////////////////////////////////////
    // Free-running clock.
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    // Main sequence.
    initial begin
        void'($urandom(32'ha70ed8fb));
        {rst_n, failures, n_checks} = '0;
        repeat (6) @(negedge clk);
        check({rdy, oe}, 2'b10);
        rst_n = 1;
        erase();
        // Flash page with both data bytes per word, then the high address byte.
        prog_u.load(PNVM_ACT_CMD, 0, 8'h10);
        for (i = 0; i < PW; i++) begin
            d16 = 16'($urandom);
            prog_u.load(PNVM_ACT_ADDR, 0, 8'(i));
            prog_u.load(PNVM_ACT_DATA, 0, d16[7:0]);
            prog_u.load(PNVM_ACT_DATA, 1, d16[15:8]);
            prog_u.latch();
            flash_m[256 + i] = d16;
        end
        prog_u.load(PNVM_ACT_ADDR, 1, 8'h01);
        do_write(0, 0);
        prog_u.load(PNVM_ACT_CMD, 0, 8'h00);
        prog_u.write_pulse(0, 0, busy);
        check(busy, 1);
        // Read back with the command and high address loaded once.
        prog_u.load(PNVM_ACT_CMD, 0, 8'h02);
        prog_u.load(PNVM_ACT_ADDR, 1, 8'h01);
        for (i = 0; i < PW; i++) begin
            prog_u.load(PNVM_ACT_ADDR, 0, 8'(i));
            rd_chk(0, 0, flash_m[256 + i][7:0]);
            rd_chk(1, 0, flash_m[256 + i][15:8]);
        end
        // EEPROM page of four bytes.
        prog_u.load(PNVM_ACT_CMD, 0, 8'h11);
        prog_u.load(PNVM_ACT_ADDR, 1, 8'h00);
        for (i = 0; i < 4; i++) begin
            d8 = 8'($urandom);
            prog_u.load(PNVM_ACT_ADDR, 0, 8'(16 + i));
            prog_u.load(PNVM_ACT_DATA, 0, d8);
            prog_u.latch();
            ee_m[16 + i] = d8;
        end
        do_write(0, 0);
        prog_u.load(PNVM_ACT_CMD, 0, 8'h03);
        for (i = 0; i < 4; i++) begin
            prog_u.load(PNVM_ACT_ADDR, 0, 8'(16 + i));
            rd_chk(0, 0, ee_m[16 + i]);
        end
        // Fuse bytes low, high and extended; the byte read back equals the data.
        prog_u.load(PNVM_ACT_CMD, 0, 8'h40);
        for (i = 0; i < 3; i++) begin
            fuse_m[i] = 8'($urandom);
            prog_u.load(PNVM_ACT_DATA, 0, fuse_m[i]);
            do_write(fb1[i], fb2[i]);
        end
        // Locks: mode 3, then a write that tries boot locks and raised bits.
        prog_u.load(PNVM_ACT_CMD, 0, 8'h20);
        prog_u.load(PNVM_ACT_DATA, 0, 8'hFC);
        do_write(0, 0);
        lock_m = 8'hFC;
        prog_u.load(PNVM_ACT_DATA, 0, 8'hC3);
        do_write(0, 0);
        prog_u.load(PNVM_ACT_CMD, 0, 8'h04);
        prog_u.load(PNVM_ACT_IDLE, 0, 8'h08);
        rd_chk(0, 0, fuse_m[0]);
        rd_chk(1, 1, fuse_m[1]);
        rd_chk(0, 1, fuse_m[2]);
        rd_chk(1, 0, lock_m);
        erase();
        prog_u.load(PNVM_ACT_CMD, 0, 8'h04);
        rd_chk(1, 0, lock_m);
        // Identification bytes and calibration.
        prog_u.load(PNVM_ACT_CMD, 0, 8'h08);
        for (i = 0; i < 3; i++) begin
            prog_u.load(PNVM_ACT_ADDR, 0, 8'(i));
            rd_chk(0, 0, SIG[i]);
        end
        prog_u.load(PNVM_ACT_ADDR, 0, 8'h00);
        rd_chk(1, 0, CAL);
        // Page through the FIFO at page zero; word zero is latched twice, the later wins.
        prog_u.load(PNVM_ACT_CMD, 0, 8'h10);
        prog_u.load(PNVM_ACT_ADDR, 1, 8'h00);
        for (i = 0; i < PW + 1; i++) begin
            d16 = 16'($urandom);
            prog_u.load(PNVM_ACT_ADDR, 0, 8'(i % PW));
            prog_u.load(PNVM_ACT_DATA, 0, d16[7:0]);
            prog_u.load(PNVM_ACT_DATA, 1, d16[15:8]);
            prog_u.latch();
            flash_m[i % PW] = d16;
        end
        do_write(0, 0);
        prog_u.load(PNVM_ACT_CMD, 0, 8'h02);
        for (i = 0; i < PW; i++) begin
            prog_u.load(PNVM_ACT_ADDR, 0, 8'(i));
            rd_chk(0, 0, flash_m[i][7:0]);
            rd_chk(1, 0, flash_m[i][15:8]);
        end
        report_and_stop();
    end
endmodule : testbench
